// *** link_host_pkg.sv ***
package link_host_pkg;

  // Register offsets
  localparam logic [11:0] HC_SET_OFS   = 12'h050;
  localparam logic [11:0] HC_CLR_OFS   = 12'h054;
  localparam logic [11:0] SID_BASE_OFS = 12'h064;

  // Offsets that live behind the PHY-side clock
  localparam logic [11:0] PHY_LO_FIRST = 12'h0DC;
  localparam logic [11:0] PHY_LO_LAST  = 12'h0F0;
  localparam logic [11:0] PHY_HI_FIRST = 12'h100;
  localparam logic [11:0] PHY_HI_LAST  = 12'h11C;

  // Host control field positions
  localparam int BIT_PERMIT = 23;
  localparam int BIT_ENH    = 22;
  localparam int BIT_LPS    = 19;
  localparam int BIT_PWE    = 18;
  localparam int BIT_LINK   = 17;
  localparam int BIT_SRST   = 16;

  // Self-ID base: 2K-byte alignment
  localparam int SID_LOW_BITS = 11;
  localparam logic [20:0] SID_BASE_RST = 21'h000000;

  // Read answers
  localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;

  // Software reset duration
  localparam int CLK_PERIOD_NS = 20;
  localparam int SRST_TIME_NS  = 200;
  localparam int SRST_CYCLES   = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SRST_LAST = 8'(SRST_CYCLES - 1);

  typedef struct packed {
    logic permit;
    logic enh;
    logic link_power_status;
    logic pwe;
    logic link;
    logic srst;
  } host_ctrl_t;

  localparam host_ctrl_t HC_RST = '{permit: 1'b1, enh: 1'b0, link_power_status: 1'b0,
                                    pwe: 1'b0, link: 1'b0, srst: 1'b0};

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        ack;
    logic        abort;
    logic [31:0] rdata;
  } reg_rsp_t;

endpackage

// *** link_host_control_regs.sv ***
`timescale 1ns/1ns
module link_host_control_regs (
  // Clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_n,
  // Register access
  input  wire link_host_pkg::reg_req_t i_req,
  output      link_host_pkg::reg_rsp_t o_rsp,
  // PHY clock status pin and PCI configuration bit
  input  wire logic                   i_phy_sclk_active,
  input  wire logic                   i_suppress_target_abort,
  // Serial EEPROM load
  input  wire logic                   i_cfg_load,
  input  wire logic                   i_cfg_phy_permit,
  // Control towards the link
  output      logic                   o_phy_comm_enable,
  output      logic                   o_phy_enhance_use,
  output      logic                   o_posted_write_allow,
  output      logic                   o_link_attached,
  output      logic                   o_soft_reset_busy,
  output      logic [31:0]            o_self_id_base
);

  logic [1:0]                rst_pipe;
  logic                      rst_n_sync;
  logic [1:0]                sclk_pipe;
  logic                      sclk_ok;
  link_host_pkg::host_ctrl_t hc;
  link_host_pkg::host_ctrl_t next_hc;
  logic [20:0]               sid;
  logic [20:0]               next_sid;
  logic [7:0]                cnt;
  logic [7:0]                next_cnt;
  link_host_pkg::reg_rsp_t   next_rsp;

  function automatic logic [31:0] hc_word(input link_host_pkg::host_ctrl_t h);
    logic [31:0] w;
    w = link_host_pkg::ZERO_WORD;  // Reserved bits stay zero
    w[link_host_pkg::BIT_PERMIT] = h.permit;
    w[link_host_pkg::BIT_ENH]    = h.enh;
    w[link_host_pkg::BIT_LPS]    = h.link_power_status;
    w[link_host_pkg::BIT_PWE]    = h.pwe;
    w[link_host_pkg::BIT_LINK]   = h.link;
    w[link_host_pkg::BIT_SRST]   = h.srst;
    return w;
  endfunction

  function automatic logic in_phy_domain(input logic [11:0] a);
    return (a >= link_host_pkg::PHY_LO_FIRST && a <= link_host_pkg::PHY_LO_LAST) ||
           (a >= link_host_pkg::PHY_HI_FIRST && a <= link_host_pkg::PHY_HI_LAST);
  endfunction

  // Reset release synchroniser
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_pipe[1];

  // PHY clock status comes from a pin, so it is synchronised first
  always_ff @(posedge i_ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      sclk_pipe <= 2'h0;
    end else begin
      sclk_pipe <= {sclk_pipe[0], i_phy_sclk_active};
    end
  end
  assign sclk_ok = sclk_pipe[1];

  always_comb begin
    next_hc  = hc;
    next_sid = sid;
    next_cnt = cnt;
    next_rsp = '0;
    if (i_req.req) begin
      if (in_phy_domain(i_req.addr) && !sclk_ok) begin
        if (i_suppress_target_abort) begin
          next_rsp.ack   = 1'b1;
          next_rsp.rdata = link_host_pkg::ALL_ONES;
        end else begin
          next_rsp.abort = 1'b1;
        end
      end else begin
        next_rsp.ack = 1'b1;
        case (i_req.addr)
          link_host_pkg::HC_SET_OFS: begin
            next_rsp.rdata = hc_word(hc);
            if (i_req.wr) begin
              // Enhancement use is not gated; software keeps the permit and link checks
              next_hc.enh  = hc.enh  | i_req.wdata[link_host_pkg::BIT_ENH];
              next_hc.link_power_status  = hc.link_power_status  | i_req.wdata[link_host_pkg::BIT_LPS];
              next_hc.pwe  = hc.pwe  | i_req.wdata[link_host_pkg::BIT_PWE];
              next_hc.link = hc.link | i_req.wdata[link_host_pkg::BIT_LINK];
              next_hc.srst = hc.srst | i_req.wdata[link_host_pkg::BIT_SRST];
            end
          end
          link_host_pkg::HC_CLR_OFS: begin
            next_rsp.rdata = hc_word(hc);
            if (i_req.wr) begin
              next_hc.enh  = hc.enh  & ~i_req.wdata[link_host_pkg::BIT_ENH];
              next_hc.link_power_status  = hc.link_power_status  & ~i_req.wdata[link_host_pkg::BIT_LPS];
              next_hc.pwe  = hc.pwe  & ~i_req.wdata[link_host_pkg::BIT_PWE];
              next_hc.link = hc.link & ~i_req.wdata[link_host_pkg::BIT_LINK];
            end
          end
          link_host_pkg::SID_BASE_OFS: begin
            next_rsp.rdata = {sid, 11'h000};
            if (i_req.wr) begin
              next_sid = i_req.wdata[31:link_host_pkg::SID_LOW_BITS];
            end
          end
          default: begin
            next_rsp.rdata = link_host_pkg::ZERO_WORD;
          end
        endcase
      end
    end
    if (i_cfg_load) begin
      next_hc.permit = i_cfg_phy_permit;
    end
    // Software reset holds every field but the reset bit at its default; the EEPROM-loaded bit is kept
    if (hc.srst) begin
      next_hc        = link_host_pkg::HC_RST;
      next_hc.permit = i_cfg_load ? i_cfg_phy_permit : hc.permit;
      next_sid       = link_host_pkg::SID_BASE_RST;
      if (cnt == link_host_pkg::SRST_LAST) begin
        next_hc.srst = 1'b0;
        next_cnt     = 8'h00;
      end else begin
        next_hc.srst = 1'b1;
        next_cnt     = cnt + 8'h01;
      end
    end
  end

  // Suppress-abort input sits outside; software reset never touches it
  always_ff @(posedge i_ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      hc    <= link_host_pkg::HC_RST;
      sid   <= link_host_pkg::SID_BASE_RST;
      cnt   <= 8'h00;
      o_rsp <= '0;
    end else begin
      hc    <= next_hc;
      sid   <= next_sid;
      cnt   <= next_cnt;
      o_rsp <= next_rsp;
    end
  end

  assign o_phy_comm_enable    = hc.link_power_status;
  assign o_phy_enhance_use    = hc.enh;
  assign o_posted_write_allow = hc.pwe;
  assign o_link_attached      = hc.link & ~hc.srst;
  assign o_soft_reset_busy    = hc.srst;
  assign o_self_id_base       = {sid, 11'h000};

  localparam int SRST_HOLD = link_host_pkg::SRST_CYCLES;
  localparam int SRST_TAIL = SRST_HOLD - 7;

  // The hold check counts eight busy cycles before its tail; the counter is eight bits
  if (SRST_HOLD < 8 || SRST_HOLD > 256) begin : g_srst_range
    $error("software reset length out of range");
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n_sync);

  sequence s_stopped_access;
    i_req.req && in_phy_domain(i_req.addr) && !sclk_ok;
  endsequence

  sequence s_srst_start;
    $rose(hc.srst);
  endsequence

  sequence s_set_write;
    i_req.req && i_req.wr && i_req.addr == link_host_pkg::HC_SET_OFS && !hc.srst;
  endsequence

  sequence s_clr_write;
    i_req.req && i_req.wr && i_req.addr == link_host_pkg::HC_CLR_OFS && !hc.srst;
  endsequence

  a_abort_stopped: assert property (
    s_stopped_access ##0 !i_suppress_target_abort |=> o_rsp.abort && !o_rsp.ack)
    else $error("stopped PHY-domain access did not abort");

  a_suppress_ones: assert property (
    s_stopped_access ##0 i_suppress_target_abort |=> o_rsp.ack && !o_rsp.abort &&
      o_rsp.rdata == 32'hFFFFFFFF)
    else $error("suppressed abort did not return all ones");

  a_srst_hold: assert property (
    s_srst_start |-> hc.srst[*8] ##SRST_TAIL !hc.srst)
    else $error("software reset length wrong");

  a_link_cleared: assert property (
    s_srst_start |=> !hc.link && !o_link_attached)
    else $error("link active survived software reset");

  a_hc_reserved: assert property (
    o_rsp.ack && ($past(i_req.addr) == 12'h050 || $past(i_req.addr) == 12'h054) |->
      o_rsp.rdata[21:20] == 2'h0 && o_rsp.rdata[15:0] == 16'h0000 &&
      o_rsp.rdata[17] == $past(hc.link))
    else $error("host control read wrong");

  a_pwe_set_clear: assert property (
    i_req.req && i_req.wr && i_req.wdata[18] && !hc.srst && sclk_ok |=>
      o_posted_write_allow == ($past(i_req.addr) == 12'h050 ? 1'b1 :
        ($past(i_req.addr) == 12'h054 ? 1'b0 : $past(hc.pwe))))
    else $error("posted write allow set/clear wrong");

  a_sid_write: assert property (
    i_req.req && i_req.wr && i_req.addr == 12'h064 && !hc.srst |=>
      o_self_id_base == {$past(i_req.wdata[31:11]), 11'h000})
    else $error("self-ID base write lost");

  a_permit_load: assert property (
    i_cfg_load |=> hc.permit == $past(i_cfg_phy_permit))
    else $error("EEPROM permit bit not loaded");

  a_phy_gate: assert property (
    $rose(o_phy_comm_enable) |-> $past(i_req.req) && $past(i_req.wr) &&
      $past(i_req.addr) == link_host_pkg::HC_SET_OFS && $past(i_req.wdata[19]))
    else $error("PHY communication enabled without a power status write");

  a_ack_or_abort: assert property (
    i_req.req |=> o_rsp.ack != o_rsp.abort)
    else $error("request answered by neither or both of ack and abort");

  a_idle_quiet: assert property (
    !i_req.req |=> !o_rsp.ack && !o_rsp.abort &&
      o_rsp.rdata == link_host_pkg::ZERO_WORD)
    else $error("answer without a request");

  a_open_offsets: assert property (
    i_req.req && !in_phy_domain(i_req.addr) |=> o_rsp.ack && !o_rsp.abort)
    else $error("host-clock offset was refused");

  a_lps_set: assert property (
    s_set_write ##0 i_req.wdata[19] |=> o_phy_comm_enable)
    else $error("link power status not set");

  a_lps_clear: assert property (
    s_clr_write ##0 i_req.wdata[19] |=> !o_phy_comm_enable)
    else $error("link power status not cleared");

  a_enh_set: assert property (
    s_set_write ##0 i_req.wdata[22] |=> o_phy_enhance_use)
    else $error("enhancement use not set");

  a_zero_writes: assert property (
    s_set_write ##0 (i_req.wdata[22] == 1'b0 && i_req.wdata[19:16] == 4'h0 && !i_cfg_load)
      |=> $stable(hc))
    else $error("set write of zeros changed host control");

  a_link_detach: assert property (
    s_clr_write ##0 i_req.wdata[17] |=> !o_link_attached)
    else $error("link stayed attached after clear");

  a_sid_read: assert property (
    i_req.req && !i_req.wr && i_req.addr == link_host_pkg::SID_BASE_OFS |=>
      o_rsp.rdata == {$past(sid), 11'h000})
    else $error("self-ID base read wrong");

  a_srst_defaults: assert property (
    s_srst_start |=> o_self_id_base == link_host_pkg::ZERO_WORD && !o_phy_comm_enable &&
      !o_posted_write_allow && !o_phy_enhance_use)
    else $error("software reset left a register set");

  a_srst_permit: assert property (
    s_srst_start ##0 !i_cfg_load |=> hc.permit == $past(hc.permit))
    else $error("software reset disturbed the EEPROM bit");

  a_srst_busy_read: assert property (
    hc.srst && i_req.req && !i_req.wr && i_req.addr == link_host_pkg::HC_SET_OFS |=>
      o_rsp.rdata[16])
    else $error("software reset bit not visible while busy");

endmodule

// *** phy_side_model.sv ***
`timescale 1ns/1ns
module phy_side_model (
  // Clock
  input  wire logic i_ref_clk,
  // Bench controls
  input  wire logic i_run,
  input  wire logic i_load,
  input  wire logic i_permit,
  // Pins towards the block
  output      logic o_phy_sclk_active = 1'b0,
  output      logic o_cfg_load        = 1'b0,
  output      logic o_cfg_phy_permit  = 1'b0
);
  // Clock status and EEPROM word arrive one cycle late, like a slow far side
  always_ff @(posedge i_ref_clk) begin
    o_phy_sclk_active <= i_run;
    o_cfg_load        <= i_load;
    // Outside a load the data line toggles so no stale value can pass
    o_cfg_phy_permit  <= i_load ? i_permit : ~o_cfg_phy_permit;
  end
endmodule

// *** tb_link_host_control_regs.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_link_host_control_regs;
  localparam logic [31:0] M = 32'h004E0000;
  logic clk = 0, rst_n = 0, run = 1, load = 0, permit = 0, supp = 0, ak, ab;
  link_host_pkg::reg_req_t rq = '0;
  link_host_pkg::reg_rsp_t rsp;
  logic sclk, cfg_load, cfg_permit, comm, enh, pwe, att, busy;
  logic [31:0] sid, rd, d, hc, seed = 32'd93;
  logic [11:0] ph [6] = '{12'h0DC, 12'h0F0, 12'h100, 12'h11C, 12'h0D8, 12'h120};
  int bad_count = 0, comparisons = 0, cyc = 0, n;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  phy_side_model partner (.i_ref_clk(clk), .i_run(run), .i_load(load), .i_permit(permit),
    .o_phy_sclk_active(sclk), .o_cfg_load(cfg_load), .o_cfg_phy_permit(cfg_permit));
  link_host_control_regs dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_req(rq), .o_rsp(rsp),
    .i_phy_sclk_active(sclk), .i_suppress_target_abort(supp), .i_cfg_load(cfg_load),
    .i_cfg_phy_permit(cfg_permit), .o_phy_comm_enable(comm), .o_phy_enhance_use(enh),
    .o_posted_write_allow(pwe), .o_link_attached(att), .o_soft_reset_busy(busy),
    .o_self_id_base(sid));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [31:0] upd(input logic [31:0] h, input logic [31:0] v, input logic c);
    return c ? (h & ~(v & M)) : (h | (v & M));
  endfunction
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    #1 rq = '{req: 1'b1, wr: wr, addr: a, wdata: v};
    @(posedge clk);
    #1 rq = '0;
    rd = rsp.rdata;
    ak = rsp.ack;
    ab = rsp.abort;
  endtask
  task automatic chk_out();
    `CHK({comm, enh, pwe, att}, {hc[19], hc[22], hc[18], hc[17]})
  endtask
  task automatic end_sim();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    hc = 32'h00800000;
    acc(0, 12'h050, '0);
    `CHK(rd, hc)
    acc(0, 12'h064, '0);
    `CHK(rd, 32'h00000000)
    $display("test reset_values done");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      d = seed | ((i < 2) ? 32'h00020000 : 32'h0);
      d[16] = 1'b0;  // Soft reset has a test of its own
      if (!(hc[23] && hc[17])) d[22] = 1'b0;
      if (hc[17]) d[18] = 1'b0;
      hc = upd(hc, d, seed[31] && i >= 2);
      acc(1, seed[31] && i >= 2 ? 12'h054 : 12'h050, d);
      `CHK(ak, 1'b1)
      chk_out();
      acc(0, seed[0] ? 12'h054 : 12'h050, '0);
      `CHK(rd, hc)
      seed = xs(seed);
      acc(1, 12'h064, seed);
      acc(0, 12'h064, '0);
      `CHK(rd, seed & 32'hFFFFF800)
      `CHK(sid, seed & 32'hFFFFF800)
    end
    $display("test set_clear_random done");
    acc(1, 12'h050, 32'h00020000);
    `CHK(att, 1'b1)
    rst_n = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    hc = 32'h00800000;
    acc(0, 12'h050, '0);
    `CHK(rd, hc)
    chk_out();
    `CHK(sid, 32'h00000000)
    $display("test hw_reset done");
    acc(1, 12'h050, 32'h00030000);
    `CHK({busy, att}, 2'b10)
    acc(0, 12'h050, '0);
    `CHK(rd[16], 1'b1)
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(n, link_host_pkg::SRST_CYCLES - 2)
    hc = 32'h00800000;
    acc(0, 12'h050, '0);
    `CHK(rd, hc)
    chk_out();
    acc(0, 12'h064, '0);
    `CHK(rd, 32'h00000000)
    $display("test soft_reset done");
    run = 0;
    repeat (4) @(posedge clk);
    for (int s = 0; s < 2; s++) begin
      supp = s[0];
      foreach (ph[k]) begin
        acc(k[0], ph[k], 32'h00000000);
        if (k < 4)
          `CHK({ab, ak, rd}, {~supp, supp, supp ? 32'hFFFFFFFF : 32'h0})
        else
          `CHK({ab, ak, rd}, {2'b01, 32'h0})
      end
    end
    supp = 0;
    run = 1;
    repeat (4) @(posedge clk);  // Settle time before any access
    acc(0, 12'h0E0, '0);
    `CHK({ab, ak}, 2'b01)
    $display("test phy_clock_domain done");
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      #1 load = 1;
      permit = p[0];
      @(posedge clk);
      #1 load = 0;
      repeat (2) @(posedge clk);
      acc(1, p[0] ? 12'h050 : 12'h054, 32'h00800000);
      acc(0, 12'h050, '0);
      `CHK(rd[23], p[0])
    end
    $display("test eeprom_load done");
    end_sim();
  end
endmodule
